/* File: rtl/gdprot_pkg.sv */
// Package of register map, field layout and reset values for the gate driver protection registers.
package gdprot_pkg;

   // Register byte offsets on the APB bus.
   localparam logic [7:0] GDPROT_CTRL_OFS = 8'h00;
   localparam logic [7:0] GDPROT_IE_OFS = 8'h04;
   localparam logic [7:0] GDPROT_DSE_OFS = 8'h08;
   localparam logic [7:0] GDPROT_LOCK_OFS = 8'h0c;
   localparam logic [7:0] GDPROT_EVF_OFS = 8'h10;
   localparam logic [7:0] GDPROT_STAT_OFS = 8'h14;

   // Control register fields.
   localparam int GDPROT_OVLVL_BIT = 7;
   localparam int GDPROT_UVLVL_BIT = 6;
   localparam int GDPROT_COARSE_LSB = 2;
   localparam int GDPROT_FINE_LSB = 0;

   // Interrupt enable fields.
   localparam int GDPROT_OCIE_LSB = 3;
   localparam int GDPROT_DSEIE_BIT = 2;
   localparam int GDPROT_HIIE_BIT = 1;
   localparam int GDPROT_LOIE_BIT = 0;

   // Desaturation flag fields.
   localparam int GDPROT_HSF_LSB = 4;
   localparam int GDPROT_LSF_LSB = 0;

   // Event flag fields, same positions as their enables.
   localparam int GDPROT_OCF_LSB = 3;
   localparam int GDPROT_HIF_BIT = 1;
   localparam int GDPROT_LOF_BIT = 0;

   // Reset values.
   localparam logic [7:0] GDPROT_CTRL_RST = 8'h00;
   localparam logic [7:0] GDPROT_IE_RST = 8'h00;
   localparam logic [7:0] GDPROT_DSE_RST = 8'h00;
   localparam logic [7:0] GDPROT_EVF_RST = 8'h00;

   // Blanking field values.
   localparam logic [3:0] GDPROT_COARSE_OFF = 4'hf;
   localparam logic [8:0] GDPROT_BLANK_EXTRA = 9'h002;

   // Blanking time in bus clock periods: (coarse + 1) * 2^(fine + 1) + 2.
   function automatic logic [8:0] gdprot_blank_cycles(input logic [3:0] coarse, input logic [1:0] fine);
      logic [8:0] base;
      base = {4'h0, coarse} + 9'h001;
      return (base << ({1'b0, fine} + 3'h1)) + GDPROT_BLANK_EXTRA;
   endfunction

endpackage

/* File: rtl/gdprot_blank.sv */
// One driver's desaturation blanking timer and error capture.
`timescale 1ns/10ps
`default_nettype none
module gdprot_blank (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Configuration
   input wire logic [8:0] blank_len,
   input wire logic capture_en,
   // Driver state
   input wire logic gate_on,
   input wire logic desat_sync,
   // Result
   output logic error_pulse
);
   logic gate_on_q;
   logic [8:0] cnt_q;
   logic [8:0] cnt_d;
   logic blanked;
   logic error_d;

   // The count restarts at each turn-on, the comparator is only believed after it ran out.
   assign blanked = cnt_q != 9'h000;
   assign cnt_d = (gate_on & ~gate_on_q) ? blank_len :
                  (blanked ? cnt_q - 9'h001 : cnt_q);
   assign error_d = capture_en & gate_on & gate_on_q & ~blanked & desat_sync;

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         gate_on_q <= 1'b0;
         cnt_q <= 9'h000;
         error_pulse <= 1'b0;
      end else begin
         gate_on_q <= gate_on;
         cnt_q <= cnt_d;
         error_pulse <= error_d;
      end
   end
endmodule // gdprot_blank
`default_nettype wire

/* File: rtl/gdprot_regs.sv */
// APB register bank and protection logic of a three-phase gate pre-driver.
// Operation
// - Control writes only while lock is clear
// - Lock stays set until reset
// - Bit 7 selects overvoltage threshold pair
// - Bit 6 selects undervoltage pair, variant-dependent
// - Blanking is ((coarse+1)*2^(fine+1)+2) cycles
// - Coarse all ones: no capture, pump disconnected
// - Interrupt enables writable regardless of lock
// - Bits 4-3 gate overcurrent interrupts
// - Bit 2 gates desaturation interrupt
// - Bit 1 gates supply overvoltage interrupt
// - Bit 0 gates lowside undervoltage interrupt
// - High-side desat error sets bits 6-4
// - Low-side desat error sets bits 2-0
// - Writing one clears a desat flag
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module gdprot_regs
#(
   parameter bit HAS_VLS_LEVEL = 1'b1,
   parameter int PHASES = 3
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Gate commands from the PWM, same clock
   input wire logic [PHASES-1:0] hs_gate_on,
   input wire logic [PHASES-1:0] ls_gate_on,
   // Comparator pins, asynchronous
   input wire logic [PHASES-1:0] hs_desat_cmp,
   input wire logic [PHASES-1:0] ls_desat_cmp,
   input wire logic [1:0] overcurrent_cmp,
   input wire logic supply_high_cmp,
   input wire logic lowside_supply_low_cmp,
   // Analog configuration
   output logic supply_overvoltage_level_select,
   output logic lowside_supply_undervoltage_level_select,
   output logic charge_pump_hs_connect,
   // Interrupt
   output logic irq
);
   import gdprot_pkg::*;

   logic [7:0] ctrl_q;
   logic [7:0] ie_q;
   logic [7:0] dse_q;
   logic [7:0] evf_q;
   logic lock_q;
   logic [7:0] ctrl_d;
   logic [7:0] ie_d;
   logic [7:0] dse_d;
   logic [7:0] evf_d;
   logic lock_d;

   // Two-stage synchronisers for the comparator pins.
   localparam int NSYNC = 2 * PHASES + 4;
   logic [NSYNC-1:0] pin_raw;
   logic [NSYNC-1:0] sync1_q;
   logic [NSYNC-1:0] sync2_q;
   logic [3:0] ev_prev_q;
   logic [3:0] ev_now;
   logic [3:0] ev_rise;

   assign pin_raw = {lowside_supply_low_cmp, supply_high_cmp, overcurrent_cmp, ls_desat_cmp, hs_desat_cmp};
   assign ev_now = sync2_q[NSYNC-1 -: 4];
   assign ev_rise = ev_now & ~ev_prev_q;

   // Bus decode. The slave answers in the first access cycle, so no wait state is ever inserted.
   logic setup_ph;
   logic wr_ok;
   logic hit_ctrl;
   logic hit_ie;
   logic hit_dse;
   logic hit_lock;
   logic hit_evf;
   logic hit_stat;
   logic mapped;
   logic [7:0] wdat;
   logic [7:0] rd_sel;
   logic slverr_d;

   assign setup_ph = psel & ~penable;
   assign wr_ok = psel & penable & pready & pwrite;
   assign hit_ctrl = paddr == GDPROT_CTRL_OFS;
   assign hit_ie = paddr == GDPROT_IE_OFS;
   assign hit_dse = paddr == GDPROT_DSE_OFS;
   assign hit_lock = paddr == GDPROT_LOCK_OFS;
   assign hit_evf = paddr == GDPROT_EVF_OFS;
   assign hit_stat = paddr == GDPROT_STAT_OFS;
   assign mapped = hit_ctrl | hit_ie | hit_dse | hit_lock | hit_evf | hit_stat;
   assign wdat = pwdata[7:0];
   assign slverr_d = setup_ph & ~mapped;

   // Reads are never blocked by the lock.
   assign rd_sel = hit_ctrl ? ctrl_q :
                   hit_ie ? ie_q :
                   hit_dse ? dse_q :
                   hit_lock ? {7'h00, lock_q} :
                   hit_evf ? evf_q :
                   hit_stat ? {4'h0, ev_now} : 8'h00;

   // Control register: frozen once the lock is set.
   logic [7:0] ctrl_mask;
   assign ctrl_mask = HAS_VLS_LEVEL ? 8'hff : 8'hbf;
   assign ctrl_d = (wr_ok & hit_ctrl & ~lock_q) ? (wdat & ctrl_mask) : ctrl_q;

   // The lock can only be set by software; nothing but reset clears it.
   assign lock_d = lock_q | (wr_ok & hit_lock & wdat[0]);

   // Interrupt enables ignore the lock.
   assign ie_d = (wr_ok & hit_ie) ? (wdat & 8'h1f) : ie_q;

   // Blanking and capture control.
   logic [3:0] coarse;
   logic [1:0] fine;
   logic [8:0] blank_len;
   logic capture_en;
   assign coarse = ctrl_q[GDPROT_COARSE_LSB +: 4];
   assign fine = ctrl_q[GDPROT_FINE_LSB +: 2];
   // Changing the blanking length while a channel is on only takes effect at its next turn-on; coarse all ones stops capture at once.
   assign blank_len = gdprot_blank_cycles(coarse, fine);
   assign capture_en = coarse != GDPROT_COARSE_OFF;

   logic [PHASES-1:0] hs_err;
   logic [PHASES-1:0] ls_err;

   genvar g;
   generate
      for (g = 0; g < PHASES; g++) begin : g_phase
         gdprot_blank u_hs (
            .core_clk(core_clk),
            .nrst(nrst),
            .blank_len(blank_len),
            .capture_en(capture_en),
            .gate_on(hs_gate_on[g]),
            .desat_sync(sync2_q[g]),
            .error_pulse(hs_err[g])
         );
         gdprot_blank u_ls (
            .core_clk(core_clk),
            .nrst(nrst),
            .blank_len(blank_len),
            .capture_en(capture_en),
            .gate_on(ls_gate_on[g]),
            .desat_sync(sync2_q[PHASES + g]),
            .error_pulse(ls_err[g])
         );
      end
   endgenerate

   // Desaturation flags: a new error wins over a clear in the same cycle.
   logic [7:0] dse_set;
   logic [7:0] dse_clr;
   assign dse_set = ({5'h00, hs_err} << GDPROT_HSF_LSB) | ({5'h00, ls_err} << GDPROT_LSF_LSB);
   assign dse_clr = (wr_ok & hit_dse) ? (wdat & 8'h77) : 8'h00;
   assign dse_d = (dse_q & ~dse_clr) | dse_set;

   // Event flags for overcurrent and supply faults, set on the comparator's rising edge.
   logic [7:0] evf_set;
   logic [7:0] evf_clr;
   assign evf_set = {3'h0, ev_rise[1:0], 1'b0, ev_rise[2], ev_rise[3]};
   assign evf_clr = (wr_ok & hit_evf) ? (wdat & 8'h1b) : 8'h00;
   assign evf_d = (evf_q & ~evf_clr) | evf_set;

   // Interrupt request: OR of every enabled source.
   logic oc_req;
   logic dse_req;
   logic hi_req;
   logic lo_req;
   logic irq_d;
   assign oc_req = |(ie_q[GDPROT_OCIE_LSB +: 2] & evf_q[GDPROT_OCF_LSB +: 2]);
   assign dse_req = ie_q[GDPROT_DSEIE_BIT] & (|dse_q);
   assign hi_req = ie_q[GDPROT_HIIE_BIT] & evf_q[GDPROT_HIF_BIT];
   assign lo_req = ie_q[GDPROT_LOIE_BIT] & evf_q[GDPROT_LOF_BIT];
   assign irq_d = oc_req | dse_req | hi_req | lo_req;

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         sync1_q <= '0;
         sync2_q <= '0;
         ev_prev_q <= 4'h0;
      end else begin
         sync1_q <= pin_raw;
         sync2_q <= sync1_q;
         ev_prev_q <= ev_now;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         ctrl_q <= GDPROT_CTRL_RST;
         ie_q <= GDPROT_IE_RST;
         dse_q <= GDPROT_DSE_RST;
         evf_q <= GDPROT_EVF_RST;
         lock_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         ie_q <= ie_d;
         dse_q <= dse_d;
         evf_q <= evf_d;
         lock_q <= lock_d;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup_ph;
         pslverr <= slverr_d;
         if (setup_ph) begin
            prdata <= {24'h00_0000, rd_sel};
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         supply_overvoltage_level_select <= 1'b0;
         lowside_supply_undervoltage_level_select <= 1'b0;
         charge_pump_hs_connect <= 1'b0;
         irq <= 1'b0;
      end else begin
         supply_overvoltage_level_select <= ctrl_q[GDPROT_OVLVL_BIT];
         lowside_supply_undervoltage_level_select <= ctrl_q[GDPROT_UVLVL_BIT];
         charge_pump_hs_connect <= capture_en;
         irq <= irq_d;
      end
   end
endmodule // gdprot_regs
`default_nettype wire

/* File: tb/gdprot_regs_chk.sv */
// Port-level assertions for the gate driver protection register bank.
`timescale 1ns/10ps
`default_nettype none
module gdprot_regs_chk
   import gdprot_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Outputs
   input wire logic supply_overvoltage_level_select,
   input wire logic lowside_supply_undervoltage_level_select,
   input wire logic charge_pump_hs_connect,
   input wire logic irq
);
   logic ap, wr_ctrl, lock_q, ie_z_q;
   logic [2:0] cfg;
   assign ap = psel && penable && pready;
   assign wr_ctrl = ap && pwrite && paddr == GDPROT_CTRL_OFS;
   assign cfg = {supply_overvoltage_level_select, lowside_supply_undervoltage_level_select, charge_pump_hs_connect};
   // Lock and enables are rebuilt from completed writes, since the checker cannot see inside.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         lock_q <= 1'b0;
         ie_z_q <= 1'b1;
      end else if (ap && pwrite) begin
         lock_q <= lock_q || (paddr == GDPROT_LOCK_OFS && pwdata[0]);
         ie_z_q <= paddr == GDPROT_IE_OFS ? pwdata[4:0] == 5'h00 : ie_z_q;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no pready");
   a_ready_single: assert property (pready |=> !pready) else $error("long pready");
   a_rdata_upper: assert property (ap && !pwrite |-> prdata[31:8] == 24'h000000) else $error("upper bits");
   a_err_unmapped: assert property (ap && paddr > GDPROT_STAT_OFS |-> pslverr) else $error("no pslverr");
   a_err_mapped: assert property (ap && paddr <= GDPROT_DSE_OFS && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("bad pslverr");
   a_ctrl_applies: assert property (wr_ctrl && !lock_q |-> ##2 cfg == {$past(pwdata[7:6], 2),
      $past(pwdata[5:2], 2) != GDPROT_COARSE_OFF}) else $error("ctrl not applied");
   a_ctrl_locked: assert property (wr_ctrl && lock_q |-> ##2 $stable(cfg)) else $error("lock broken");
   a_irq_masked: assert property (ie_z_q && $past(ie_z_q) && $past(ie_z_q, 2) |-> !irq)
      else $error("irq masked");
   c_locked_write: cover property (wr_ctrl && lock_q);
   c_irq: cover property (irq);
   c_slverr: cover property (ap && pslverr);
endmodule // gdprot_regs_chk
bind gdprot_regs gdprot_regs_chk gdprot_regs_chk_inst (.core_clk(core_clk), .nrst(nrst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .supply_overvoltage_level_select(supply_overvoltage_level_select),
   .lowside_supply_undervoltage_level_select(lowside_supply_undervoltage_level_select),
   .charge_pump_hs_connect(charge_pump_hs_connect), .irq(irq));
`default_nettype wire

/* File: tb/gdprot_fet_model.sv */
// Half-bridge model driving the desaturation comparators.
`timescale 1ns/10ps
`default_nettype none
module gdprot_fet_model #(parameter int DLY = 3) (
   // Clock
   input wire logic core_clk,
   // Gate commands and injected faults
   input wire logic [5:0] gate_on,
   input wire logic [5:0] fault,
   // Comparator levels
   output logic [5:0] desat_cmp
);
   logic [2:0] age_q [6];
   // An off or just switched FET sits at full drain voltage, so it reads as desaturated until it settles.
   always_ff @(posedge core_clk) begin
      for (int i = 0; i < 6; i++) begin
         age_q[i] <= !gate_on[i] ? 3'h0 : age_q[i] + 3'(age_q[i] != DLY[2:0]);
         desat_cmp[i] <= !gate_on[i] || fault[i] || age_q[i] != DLY[2:0];
      end
   end
endmodule // gdprot_fet_model
`default_nettype wire

/* File: tb/tb_gdprot_regs.sv */
// Self-checking bench for the gate driver protection register bank.
`timescale 1ns/10ps
`default_nettype none
module tb_gdprot_regs;
   import gdprot_pkg::*;
   localparam int BLANK = ((1 + 1) << (1 + 1)) + 2;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [5:0] gate = 6'h00;
   logic [5:0] fault = 6'h00;
   logic [3:0] ev = 4'h0;
   logic [31:0] prdata, rd;
   logic [5:0] cmp;
   logic pready, pslverr, ov_sel, uv_sel, pump, irq, err;
   int bad_count = 0;
   int cmp_count = 0;
   logic [7:0] ie_tbl [4] = '{8'h08, 8'h10, 8'h02, 8'h01};
   always #10 core_clk = ~core_clk;
   gdprot_regs gdprot_regs_inst (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .hs_gate_on(gate[2:0]), .ls_gate_on(gate[5:3]), .hs_desat_cmp(cmp[2:0]), .ls_desat_cmp(cmp[5:3]),
      .overcurrent_cmp(ev[1:0]), .supply_high_cmp(ev[2]), .lowside_supply_low_cmp(ev[3]),
      .supply_overvoltage_level_select(ov_sel), .lowside_supply_undervoltage_level_select(uv_sel),
      .charge_pump_hs_connect(pump), .irq(irq));
   gdprot_fet_model gdprot_fet_model_inst (.core_clk(core_clk), .gate_on(gate), .fault(fault), .desat_cmp(cmp));
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      logic got;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      // The answer is read once settled, then the edge that samples it ends the access.
      do begin
         #1;
         got = pready === 1'b1;
         rd = prdata;
         err = pslverr;
         @(posedge core_clk);
      end while (!got);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task tick(input int c);
      repeat (c) @(posedge core_clk);
      #1;
   endtask
   task wrap_up();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge core_clk);
      bad_count++;
      wrap_up();
   end
   initial begin
      repeat (16) @(posedge core_clk);
      nrst <= 1'b1;
      rdc(GDPROT_CTRL_OFS, 32'h0);
      rdc(GDPROT_IE_OFS, 32'h0);
      rdc(GDPROT_DSE_OFS, 32'h0);
      xfer(1'b1, GDPROT_CTRL_OFS, 32'h80);
      rdc(GDPROT_CTRL_OFS, 32'h80);
      #1 chk(ov_sel, 1'b1);
      xfer(1'b1, GDPROT_CTRL_OFS, 32'h7c);
      tick(2);
      chk({ov_sel, uv_sel, pump}, 3'b010);
      @(posedge core_clk);
      gate <= 6'h01;
      fault <= 6'h01;
      tick(40);
      rdc(GDPROT_DSE_OFS, 32'h0);
      gate <= 6'h00;
      fault <= 6'h00;
      xfer(1'b1, GDPROT_CTRL_OFS, 32'h05);
      xfer(1'b1, GDPROT_IE_OFS, 32'h04);
      tick(2);
      chk(pump, 1'b1);
      @(posedge core_clk);
      gate <= 6'h23;
      fault <= 6'h21;
      tick(BLANK - 1);
      chk(irq, 1'b0);
      tick(7);
      chk(irq, 1'b1);
      rdc(GDPROT_DSE_OFS, 32'h14);
      xfer(1'b1, GDPROT_DSE_OFS, 32'h00);
      rdc(GDPROT_DSE_OFS, 32'h14);
      gate <= 6'h00;
      fault <= 6'h00;
      xfer(1'b1, GDPROT_DSE_OFS, 32'h10);
      rdc(GDPROT_DSE_OFS, 32'h04);
      xfer(1'b1, GDPROT_DSE_OFS, 32'h04);
      tick(3);
      chk(irq, 1'b0);
      for (int k = 0; k < 4; k++) begin
         xfer(1'b1, GDPROT_IE_OFS, 32'h0);
         ev <= 4'h1 << k;
         tick(8);
         chk(irq, 1'b0);
         rdc(GDPROT_STAT_OFS, 32'h1 << k);
         xfer(1'b1, GDPROT_IE_OFS, {24'h0, ie_tbl[k]});
         tick(3);
         chk(irq, 1'b1);
         rdc(GDPROT_EVF_OFS, {24'h0, ie_tbl[k]});
         @(posedge core_clk);
         ev <= 4'h0;
         xfer(1'b1, GDPROT_EVF_OFS, {24'h0, ie_tbl[k]});
         tick(3);
         chk(irq, 1'b0);
      end
      xfer(1'b0, 8'h40, 32'h0);
      chk({err, rd[7:0]}, 9'h100);
      xfer(1'b1, GDPROT_LOCK_OFS, 32'h01);
      xfer(1'b1, GDPROT_CTRL_OFS, 32'hff);
      rdc(GDPROT_CTRL_OFS, 32'h05);
      xfer(1'b1, GDPROT_LOCK_OFS, 32'h00);
      xfer(1'b1, GDPROT_CTRL_OFS, 32'h80);
      rdc(GDPROT_CTRL_OFS, 32'h05);
      #1 chk({ov_sel, pump}, 2'b01);
      xfer(1'b1, GDPROT_IE_OFS, 32'h1f);
      rdc(GDPROT_IE_OFS, 32'h1f);
      nrst <= 1'b0;
      repeat (3) @(posedge core_clk);
      nrst <= 1'b1;
      xfer(1'b1, GDPROT_CTRL_OFS, 32'h80);
      rdc(GDPROT_CTRL_OFS, 32'h80);
      wrap_up();
   end
endmodule // tb_gdprot_regs
`default_nettype wire
